/* hw/supply_monitor_map.vh */
// register offsets, field positions and timing counts for the supply monitor control
// assumes a 50 MHz system clock and an AXI4-Lite register bus with 32-bit data
`ifndef SUPPLY_MONITOR_MAP_VH
`define SUPPLY_MONITOR_MAP_VH

// printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define IDX_DETECTOR_CONTROL_A        4'h0
`define IDX_DETECTOR_THRESHOLD_SELECT 4'h1
`define IDX_WARNING_LEVEL_CONTROL     4'h8
`define IDX_WARNING_INTERRUPT_CONTROL 4'h9
`define IDX_WARNING_INTERRUPT_FLAGS   4'hA
`define IDX_WARNING_LEVEL_STATUS      4'hB
`define IDX_CONFIG_CHANGE_GUARD       4'hC

// detector_control_a fields
`define SAMPLE_RATE_BIT   4
`define ACTIVE_MODE_HI    3
`define ACTIVE_MODE_LO    2
`define SLEEP_MODE_HI     1
`define SLEEP_MODE_LO     0

// detector modes
`define MODE_DISABLED     2'h0
`define MODE_ENABLED      2'h1
`define MODE_SAMPLED      2'h2
`define MODE_ENWAKE       2'h3

// warning trigger directions
`define TRIG_BELOW        2'h0
`define TRIG_ABOVE        2'h1
`define TRIG_CROSS        2'h2

// warning threshold offsets in percent
`define PCT_LEVEL0        8'h05
`define PCT_LEVEL1        8'h0F
`define PCT_LEVEL2        8'h19

// unlock key and window in processor instructions
`define IO_REGISTER_UNLOCK_KEY 8'hD8
`define UNLOCK_WINDOW_INSNS    4

// sample periods in microseconds
`define SAMPLE_PERIOD_FAST_US 1000
`define SAMPLE_PERIOD_SLOW_US 8000
`define CLOCK_MHZ             50

`endif

/* hw/supply_monitor_ctrl.v */
// digital control of the under-voltage detector and the supply warning monitor
// assumes analog comparators sampled synchronously; fuse bits stable at reset release
// Overview of operation
// RQ1 - load threshold and modes from fuses
// RQ2 - only sleep mode writable by software
// RQ3 - supply below threshold requests reset
// RQ4 - continuous or briefly sampled comparison
// RQ5 - entering sleep selects sleep mode field
// RQ6 - waking restores active mode field
// RQ7 - irq enable bit turns monitor on
// RQ8 - request on crossing in chosen direction
// RQ9 - direction code: below, above, either
// RQ10 - detector disabled keeps monitor inactive
// RQ11 - sampled detector samples monitor too
// RQ12 - monitor threshold percent above detector
// RQ13 - level code: 5, 15, 25 percent
// RQ14 - crossing sets monitor flag
// RQ15 - irq while flag and enable set
// RQ16 - no irq while processor debug-halted
// RQ17 - key then write within four instructions
// RQ18 - unlocked-less write leaves field unchanged
// RQ19 - only sleep field guarded, io key
// RQ20 - control register bit layout fixed
// RQ21 - write one clears flag
`timescale 1ns/100ps
`include "supply_monitor_map.vh"
`default_nettype none

module supply_monitor_ctrl #(
  parameter integer FAST_PERIOD_CYCLES = `SAMPLE_PERIOD_FAST_US * `CLOCK_MHZ,
  parameter integer SLOW_PERIOD_CYCLES = `SAMPLE_PERIOD_SLOW_US * `CLOCK_MHZ,
  parameter integer SAMPLE_ON_CYCLES   = 4
) (
  input  wire        aclk,
  input  wire        aresetn,
  // fuse configuration
  input  wire [2:0]  fuse_threshold_level,
  input  wire [1:0]  fuse_active_mode,
  input  wire [1:0]  fuse_sleep_mode,
  input  wire        fuse_sample_rate,
  // system state
  input  wire        sleep_deep,
  input  wire        debug_halt,
  input  wire        insn_retire,
  // analog side, then reset_request, warning_irq and wake_hold towards the system
  input  wire        supply_below_detector,
  input  wire        supply_below_warning,
  output reg         detector_power,
  output reg  [2:0]  detector_threshold_level,
  output reg  [7:0]  warning_threshold_pct,
  output reg         warning_comparator_power,
  output reg         reset_request,
  output wire        warning_irq,
  output wire        wake_hold,
  // AXI4-Lite slave
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [1:0] RESP_OKAY   = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;
  // one-hot phases of a sample
  localparam [1:0] PH_IDLE = 2'h1;
  localparam [1:0] PH_ON   = 2'h2;

  reg        loaded_q;
  reg        sample_rate_q;
  reg  [1:0] active_mode_q;
  reg  [1:0] sleep_mode_q;
  reg  [2:0] level_q;
  reg  [1:0] warn_level_q;
  reg  [1:0] warn_dir_q;
  reg        warn_ie_q;
  reg        warn_flag_q;
  reg        warn_status_q;
  reg        warn_prev_q;
  reg        warn_valid_q;
  reg  [2:0] unlock_cnt_q;
  reg  [1:0] phase_q;
  reg [19:0] period_cnt_q;
  reg  [7:0] on_cnt_q;
  reg        aw_held_q;
  reg  [5:0] aw_addr_q;
  reg        w_held_q;
  reg [31:0] w_data_q;
  reg  [3:0] w_strb_q;

  // index of a word-aligned byte address; misaligned or out of range gives an unused index
  function [3:0] reg_index;
    input [5:0] addr;
    begin
      reg_index = (addr[1:0] == 2'h0) ? addr[5:2] : 4'hF;
    end
  endfunction

  // reserved level code gives no offset rather than a guess
  function [7:0] pct_of_level;
    input [1:0] code;
    begin
      case (code)
        2'h0:    pct_of_level = `PCT_LEVEL0;
        2'h1:    pct_of_level = `PCT_LEVEL1;
        2'h2:    pct_of_level = `PCT_LEVEL2;
        default: pct_of_level = 8'h00;
      endcase
    end
  endfunction

  // effective detector mode: sleep field in deep sleep, active field otherwise
  // enwake is refused in the sleep field, so it only keeps the detector off if fused there
  wire [1:0] mode_now = sleep_deep ? sleep_mode_q : active_mode_q; // RQ5 RQ6
  wire       det_on   = loaded_q && (mode_now != `MODE_DISABLED) &&
                        !(sleep_deep && mode_now == `MODE_ENWAKE);
  wire       sampled  = (mode_now == `MODE_SAMPLED); // RQ4
  wire       sample_instant = sampled ? (phase_q == PH_ON && on_cnt_q == 8'h01) : 1'b1; // RQ11
  wire       warn_active = det_on && warn_ie_q; // RQ7 RQ10
  // an unpowered comparator output means nothing: trust it only once its power
  // enable has stood for an edge, and only at the sample instant of the mode
  wire       det_trusted  = det_on && detector_power && sample_instant; // RQ3 RQ11
  wire       warn_trusted = warn_active && warning_comparator_power && sample_instant; // RQ10 RQ11

  // write channel
  // a new address and data pair waits until the previous response is taken
  wire       w_go      = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
  wire [5:0] w_addr    = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] w_dat    = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] w_stb     = w_held_q ? w_strb_q : s_axi_wstrb;
  wire [3:0] w_idx     = reg_index(w_addr);
  wire       w_lane0   = w_go && w_stb[0];
  wire       w_known   = (w_idx == `IDX_DETECTOR_CONTROL_A) || (w_idx == `IDX_DETECTOR_THRESHOLD_SELECT) ||
                         (w_idx == `IDX_WARNING_LEVEL_CONTROL) || (w_idx == `IDX_WARNING_INTERRUPT_CONTROL) ||
                         (w_idx == `IDX_WARNING_INTERRUPT_FLAGS) || (w_idx == `IDX_WARNING_LEVEL_STATUS) ||
                         (w_idx == `IDX_CONFIG_CHANGE_GUARD);

  // ready is refused while a half is held or a response waits
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // crossing detection on the warning comparator
  // a crossing needs two trusted samples in a row; the first after enable gives none
  wire cross_down = warn_valid_q && !warn_prev_q && supply_below_warning;
  wire cross_up   = warn_valid_q && warn_prev_q && !supply_below_warning;
  // reserved direction codes never trigger
  reg  trig;
  always @* begin
    case (warn_dir_q) // RQ9
      `TRIG_BELOW: trig = cross_down;
      `TRIG_ABOVE: trig = cross_up;
      `TRIG_CROSS: trig = cross_down || cross_up;
      default:     trig = 1'b0;
    endcase
  end
  wire warn_event = warn_trusted && trig; // RQ8

  assign warning_irq = warn_flag_q && warn_ie_q && !debug_halt; // RQ15 RQ16
  // holds execution after wake until the detector runs, only in the enwake active mode
  assign wake_hold   = loaded_q && !sleep_deep && active_mode_q == `MODE_ENWAKE && !detector_power;

  // fuse load and configuration registers
  // fuse levels are taken once, on the first edge after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      loaded_q      <= 1'b0;
      sample_rate_q <= 1'b0;
      active_mode_q <= `MODE_DISABLED;
      sleep_mode_q  <= `MODE_DISABLED;
      level_q       <= 3'h0;
      warn_level_q  <= 2'h0;
      warn_dir_q    <= 2'h0;
      warn_ie_q     <= 1'b0;
      unlock_cnt_q  <= 3'h0;
    end else begin
      if (!loaded_q) begin
        loaded_q      <= 1'b1;
        sample_rate_q <= fuse_sample_rate; // RQ1
        active_mode_q <= fuse_active_mode;
        sleep_mode_q  <= fuse_sleep_mode;
        level_q       <= fuse_threshold_level;
      end
      // the key write itself does not count; the window closes on the fourth retire
      // each retired instruction closes the unlock window by one
      if (w_lane0 && w_idx == `IDX_CONFIG_CHANGE_GUARD && w_dat[7:0] == `IO_REGISTER_UNLOCK_KEY)
        unlock_cnt_q <= 3'd`UNLOCK_WINDOW_INSNS; // RQ17
      else if (w_lane0 && w_idx == `IDX_DETECTOR_CONTROL_A)
        unlock_cnt_q <= 3'h0;
      else if (insn_retire && unlock_cnt_q != 3'h0)
        unlock_cnt_q <= unlock_cnt_q - 3'h1;
      // a refused write still gets an okay response, as for a read-only field
      // reserved sleep code is refused; other fields ignore writes
      if (loaded_q && w_lane0 && w_idx == `IDX_DETECTOR_CONTROL_A && unlock_cnt_q != 3'h0 &&
          w_dat[`SLEEP_MODE_HI:`SLEEP_MODE_LO] != `MODE_ENWAKE)
        sleep_mode_q <= w_dat[`SLEEP_MODE_HI:`SLEEP_MODE_LO]; // RQ2 RQ18 RQ19
      if (w_lane0 && w_idx == `IDX_WARNING_LEVEL_CONTROL)
        warn_level_q <= w_dat[1:0];
      if (w_lane0 && w_idx == `IDX_WARNING_INTERRUPT_CONTROL) begin
        warn_dir_q <= w_dat[2:1];
        warn_ie_q  <= w_dat[0];
      end
    end
  end

  // sample timing: brief power-on once per period
  // the sample falls in the last on-cycle so the comparator has had time to settle
  // 20-bit period counter covers the slow period at 50 MHz; a clock above 131 MHz needs more bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_q      <= PH_IDLE;
      period_cnt_q <= 20'h00000;
      on_cnt_q     <= 8'h00;
    end else if (!sampled || !det_on) begin
      phase_q      <= PH_IDLE;
      period_cnt_q <= 20'h00000;
      on_cnt_q     <= 8'h00;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          if (period_cnt_q == 20'h00000) begin
            phase_q  <= PH_ON;
            on_cnt_q <= SAMPLE_ON_CYCLES[7:0];
            period_cnt_q <= sample_rate_q ? SLOW_PERIOD_CYCLES[19:0] - 20'h1
                                          : FAST_PERIOD_CYCLES[19:0] - 20'h1;
          end else begin
            period_cnt_q <= period_cnt_q - 20'h1;
          end
        end
        PH_ON: begin
          if (period_cnt_q != 20'h00000)
            period_cnt_q <= period_cnt_q - 20'h1;
          if (on_cnt_q == 8'h01)
            phase_q <= PH_IDLE;
          on_cnt_q <= on_cnt_q - 8'h01;
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // analog drive: power enables and threshold selection towards the comparators
  // the threshold copies follow the registers one edge late
  always @(posedge aclk) begin
    if (!aresetn) begin
      detector_power           <= 1'b0;
      detector_threshold_level <= 3'h0;
      warning_threshold_pct    <= 8'h00;
      warning_comparator_power <= 1'b0;
    end else begin
      detector_power           <= det_on && (!sampled || phase_q == PH_ON); // RQ4
      detector_threshold_level <= level_q;
      warning_threshold_pct    <= pct_of_level(warn_level_q); // RQ12 RQ13
      warning_comparator_power <= warn_active && (!sampled || phase_q == PH_ON);
    end
  end

  // reset request: stands until a later trusted sample sees the supply good or the detector turns off
  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_request <= 1'b0;
    end else if (det_trusted) begin
      reset_request <= supply_below_detector; // RQ3
    end else if (!det_on) begin
      reset_request <= 1'b0;
    end
  end

  // warning state and flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      warn_flag_q   <= 1'b0;
      warn_status_q <= 1'b0;
      warn_prev_q   <= 1'b0;
      warn_valid_q  <= 1'b0;
    end else begin
      // status follows every trusted sample; it means nothing while the detector is off
      if (warn_trusted) begin
        warn_prev_q   <= supply_below_warning;
        warn_valid_q  <= 1'b1;
        warn_status_q <= supply_below_warning;
      end else if (!warn_active) begin
        warn_valid_q <= 1'b0;
      end
      // a new event wins over a clear in the same cycle
      if (warn_event)
        warn_flag_q <= 1'b1; // RQ14
      else if (w_lane0 && w_idx == `IDX_WARNING_INTERRUPT_FLAGS && w_dat[0])
        warn_flag_q <= 1'b0; // RQ21
    end
  end

  // register bus: write side holds whichever half arrives first
  // response code is registered with bvalid and stands until bready
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      aw_addr_q    <= 6'h00;
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (w_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_known ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register bus: read side
  // reads have no side effects, so status and flags may be polled freely
  reg [7:0] rd_byte;
  reg       rd_known;
  always @* begin
    rd_known = 1'b1;
    case (reg_index(s_axi_araddr))
      `IDX_DETECTOR_CONTROL_A:        rd_byte = {3'h0, sample_rate_q, active_mode_q, sleep_mode_q}; // RQ20
      `IDX_DETECTOR_THRESHOLD_SELECT: rd_byte = {5'h00, level_q};
      `IDX_WARNING_LEVEL_CONTROL:     rd_byte = {6'h00, warn_level_q};
      `IDX_WARNING_INTERRUPT_CONTROL: rd_byte = {5'h00, warn_dir_q, warn_ie_q};
      `IDX_WARNING_INTERRUPT_FLAGS:   rd_byte = {7'h00, warn_flag_q};
      `IDX_WARNING_LEVEL_STATUS:      rd_byte = {7'h00, warn_status_q};
      `IDX_CONFIG_CHANGE_GUARD:       rd_byte = {5'h00, unlock_cnt_q};
      default: begin
        rd_byte  = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // supply_monitor_ctrl

`default_nettype wire

/* test/brownout_checker_sva.sv */
// checker for the supply monitor control, bound to its top module
// sees only top ports; one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module brownout_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        debug_halt,
  input wire logic        supply_below_detector,
  input wire logic        detector_power,
  input wire logic        warning_comparator_power,
  input wire logic        reset_request,
  input wire logic        warning_irq,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_debug_mask:
    assert property (debug_halt |-> !warning_irq) else $error("irq during debug halt");
  a_irq_held:
    assert property (warning_irq && !s_axi_awvalid && !s_axi_wvalid |=> warning_irq || debug_halt)
      else $error("irq dropped without a write");
  a_write_answer:
    assert property (s_wr_taken |=> s_axi_bvalid) else $error("no write response");
  a_read_answer:
    assert property (s_rd_taken |=> s_axi_rvalid) else $error("no read data");
  a_bvalid_once:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
  a_rvalid_once:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data repeated");
  a_reset_cause:
    assert property ($rose(reset_request) |-> $past(supply_below_detector)) else $error("reset without low supply");
  a_monitor_follows:
    assert property (warning_comparator_power |-> detector_power) else $error("monitor on, detector off");
endmodule // brownout_checker
bind supply_monitor_ctrl brownout_checker u_chk (.*);
`default_nettype wire

/* test/supply_comparator_model.sv */
// behavioural comparators on the analog side of the monitor control
// bench sets the supply state; powered outputs follow it without delay
`timescale 1ns/100ps
`default_nettype none
module supply_comparator_model (
  input wire logic  aclk,
  input wire logic  detector_power,
  input wire logic  warning_comparator_power,
  input wire logic  supply_low,
  input wire logic  supply_warn,
  output var logic  supply_below_detector,
  output var logic  supply_below_warning
);
  logic idle_q = 1'b0;
  // unpowered output means nothing, so it keeps changing
  always @(posedge aclk) idle_q <= ~idle_q;
  // a powered comparator is continuous, so no register sits in the powered path
  assign supply_below_detector = detector_power ? supply_low : idle_q;
  assign supply_below_warning = warning_comparator_power ? supply_warn : ~idle_q;
endmodule // supply_comparator_model
`default_nettype wire

/* test/brownout_supply_monitor_ctrl_tb.sv */
// self-checking bench for the supply monitor control
// axi4-lite master tasks; comparator model on the analog side
`timescale 1ns/100ps
`default_nettype none
module brownout_supply_monitor_ctrl_tb;
  logic aclk, aresetn, sleep_deep, debug_halt, insn_retire, supply_low, supply_warn;
  logic supply_below_detector, supply_below_warning, detector_power, warning_comparator_power;
  logic reset_request, warning_irq, wake_hold;
  logic [2:0] detector_threshold_level;
  logic [7:0] warning_threshold_pct;
  logic [2:0] fuse_threshold_level = 3'h5;
  logic [1:0] fuse_active_mode = 2'h1;
  logic [1:0] fuse_sleep_mode = 2'h2;
  logic fuse_sample_rate = 1'b0;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] pct [4] = '{8'h05, 8'h0F, 8'h19, 8'h00};
  int fails, checks_done, n;
  // short sample periods keep the run brief
  supply_monitor_ctrl #(.FAST_PERIOD_CYCLES(20), .SLOW_PERIOD_CYCLES(40), .SAMPLE_ON_CYCLES(4)) dut (.*);
  supply_comparator_model u_cmp (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic pa, pw, pb, ao, wo;
    pa = 1;
    pw = 1;
    pb = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50 && pb; k++) begin
      @(negedge aclk);
      ao = pa && s_axi_awready;
      wo = pw && s_axi_wready;
      rr = s_axi_bresp;
      pb = !s_axi_bvalid;
      @(posedge aclk);
      if (ao) s_axi_awvalid <= 1'b0;
      if (wo) s_axi_wvalid <= 1'b0;
      pa = pa && !ao;
      pw = pw && !wo;
    end
    if (pb) fails++;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a);
    logic pa, pr;
    pa = 1;
    pr = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50 && pr; k++) begin
      @(negedge aclk);
      if (pa && s_axi_arready) pa = 0;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      pr = !s_axi_rvalid;
      @(posedge aclk);
      if (!pa) s_axi_arvalid <= 1'b0;
    end
    if (pr) fails++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {aresetn, sleep_deep, debug_halt, insn_retire, supply_low, supply_warn} = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'h1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(6'h00);
    chk(rv, 32'h06);
    rd(6'h04);
    chk(rv, 32'h05);
    chk(detector_threshold_level, 3'h5);
    chk(wake_hold, 1'b0);
    wr(6'h00, 32'h1D);
    chk(rr, 2'h0);
    rd(6'h00);
    chk(rv, 32'h06);
    wr(6'h04, 32'h02);
    rd(6'h04);
    chk(rv, 32'h05);
    rd(6'h08);
    chk(rr, 2'h2);
    wr(6'h08, 32'h0);
    chk(rr, 2'h2);
    sleep_deep <= 1'b1;
    repeat (5) @(posedge aclk);
    n = 0;
    repeat (40) begin
      @(negedge aclk);
      n += detector_power;
    end
    @(posedge aclk);
    chk(n, 8);
    sleep_deep <= 1'b0;
    repeat (3) @(posedge aclk);
    n = 0;
    repeat (10) begin
      @(negedge aclk);
      n += detector_power;
    end
    @(posedge aclk);
    chk(n, 10);
    wr(6'h30, 32'hD8);
    wr(6'h00, 32'h01);
    rd(6'h00);
    chk(rv, 32'h05);
    wr(6'h30, 32'hD8);
    // window spent by four retired instructions
    repeat (4) begin
      insn_retire <= 1'b1;
      @(posedge aclk);
      insn_retire <= 1'b0;
      @(posedge aclk);
    end
    wr(6'h00, 32'h02);
    rd(6'h00);
    chk(rv, 32'h05);
    for (int c = 0; c < 4; c++) begin
      wr(6'h20, c);
      repeat (2) @(posedge aclk);
      chk(warning_threshold_pct, pct[c]);
    end
    for (int d = 0; d < 3; d++) begin
      wr(6'h24, (d << 1) | 1);
      repeat (3) @(posedge aclk);
      supply_warn <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(6'h28);
      chk(rv, d != 1);
      rd(6'h2C);
      chk(rv, 32'h1);
      if (d == 0) begin
        chk(warning_irq, 1'b1);
        debug_halt <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(warning_irq, 1'b0);
        debug_halt <= 1'b0;
        wr(6'h28, 32'h0);
        rd(6'h28);
        chk(rv, 32'h1);
      end
      wr(6'h28, 32'h1);
      rd(6'h28);
      chk(rv, 32'h0);
      supply_warn <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(6'h28);
      chk(rv, d != 0);
      wr(6'h28, 32'h1);
    end
    wr(6'h30, 32'hD8);
    wr(6'h00, 32'h00);
    sleep_deep <= 1'b1;
    repeat (4) @(posedge aclk);
    supply_warn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(warning_comparator_power, 1'b0);
    sleep_deep <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(6'h28);
    chk(rv, 32'h0);
    supply_low <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(reset_request, 1'b1);
    supply_low <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(reset_request, 1'b0);
    // second reset: fuses now ask for the enwake active mode and the slow rate
    aresetn <= 1'b0;
    fuse_threshold_level <= 3'h2;
    fuse_active_mode <= 2'h3;
    fuse_sample_rate <= 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(6'h00);
    chk(rv, 32'h1E);
    chk(detector_threshold_level, 3'h2);
    sleep_deep <= 1'b1;
    repeat (5) @(posedge aclk);
    n = 0;
    repeat (80) begin
      @(negedge aclk);
      n += detector_power;
    end
    chk(n, 8);
    // wake just after an on-phase ends, so the detector is surely off
    wait (detector_power);
    wait (!detector_power);
    @(posedge aclk);
    sleep_deep <= 1'b0;
    @(negedge aclk);
    chk(wake_hold, 1'b1);
    @(negedge aclk);
    chk(wake_hold, 1'b0);
    chk(detector_power, 1'b1);
    @(posedge aclk);
    close_out;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    close_out;
  end
endmodule // brownout_supply_monitor_ctrl_tb
`default_nettype wire
